// ===== core/cbs_balance_status.sv
// balancing status, launch validation, pin levels and diag ready flags
//
// Chosen here: the strobed register port.
`timescale 1ns/1ps
module cbs_balance_status
	import cbs_pkg::*;
(
	// clock, reset, enable
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic i_ce,
	// register port
	input wire logic [ADDR_W-1:0] i_addr,
	input wire logic [DATA_W-1:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [DATA_W-1:0] o_rdata,
	// balancing engine events, same clock
	input wire logic i_cell_done,
	input wire logic i_module_done,
	input wire logic i_fault,
	input wire logic i_heat_warn,
	input wire logic [THERM_N*4-1:0] i_therm_reading,
	// diagnostic engine events, same clock
	input wire logic i_switch_diag_done,
	input wire logic i_aux_diag_done,
	// general-purpose pins, asynchronous
	input wire logic [7:0] i_pin_level,
	// controls to the engines
	output logic o_balance_go,
	output logic o_balance_pause,
	output logic o_balance_abort,
	output logic [CELL_N-1:0] o_cell_select,
	output logic [DATA_W-1:0] o_module_timer,
	output logic o_diag_start,
	// interrupt
	output logic o_irq
);

	// ************************************************************
	// declarations
	// ************************************************************
	logic [CELL_N-1:0] cell_sel_q;
	logic forbid_neighbour_q;
	logic therm_check_on_q;
	logic [OTCFG_THR_W-1:0] therm_thr_q;
	logic [DATA_W-1:0] module_timer_q;
	logic host_pause_q;
	logic bad_setting_q;
	logic overtemp_q;
	logic paused_q;
	logic cell_run_q;
	logic module_run_q;
	logic abort_q;
	logic module_done_q;
	logic cell_done_q;
	logic switch_ready_q;
	logic aux_ready_q;
	logic [DATA_W-1:0] irq_status_q;
	logic [DATA_W-1:0] irq_mask_q;
	logic [7:0] pin_sync;
	logic [7:0] pin_level_q;
	logic bad_now;
	logic wr_ctrl;
	logic launch_wr;
	logic launch_ok;
	logic diag_start_wr;
	logic overtemp_now;
	logic pause_now;
	logic abort_now;
	logic [DATA_W-1:0] irq_events;
	logic [DATA_W-1:0] bal_status;

	// ************************************************************
	// helpers
	// ************************************************************
	// true when any 4-bit thermistor reading exceeds the threshold
	function automatic logic any_above(input logic [THERM_N*4-1:0] rd,
		input logic [OTCFG_THR_W-1:0] thr);
		logic hit;
		hit = 1'b0;
		for (int k = 0; k < THERM_N; k++) begin
			hit = hit | (rd[k*4 +: 4] > thr);
		end
		return hit;
	endfunction

	// a write strobe hitting one register address
	function automatic logic hit_wr(input logic wr, input logic [ADDR_W-1:0] a,
		input logic [ADDR_W-1:0] ofs);
		return wr && (a == ofs);
	endfunction

	// ************************************************************
	// submodules
	// ************************************************************
	// pin levels come from outside the clock domain
	cbs_sync #(
		.WIDTH(8)
	) u_pin_sync (
		.i_clk(i_clk),
		.i_rst(i_rst),
		.i_ce(i_ce),
		.i_async(i_pin_level),
		.o_sync(pin_sync)
	);

	cbs_cfg_check u_cfg_check (
		.i_cells(cell_sel_q),
		.i_forbid_neighbour(forbid_neighbour_q),
		.o_bad(bad_now)
	);

	// ************************************************************
	// command decode
	// ************************************************************
	assign wr_ctrl = hit_wr(i_wr, i_addr, BALANCE_CTRL_OFS);
	assign launch_wr = wr_ctrl && i_wdata[CTRL_LAUNCH_BIT];
	assign launch_ok = launch_wr && !bad_now;
	assign diag_start_wr = hit_wr(i_wr, i_addr, DIAG_CTRL_OFS) && i_wdata[DIAG_START_BIT];

	// overtemp only counts once balancing has been launched and is running
	assign overtemp_now = cell_run_q &&
		((therm_check_on_q && any_above(i_therm_reading, therm_thr_q))
		|| i_heat_warn);
	assign pause_now = cell_run_q && (overtemp_now || host_pause_q);
	// abort is held off while paused and returns when the pause ends
	assign abort_now = cell_run_q && i_fault && !paused_q && !launch_wr;

	// ************************************************************
	// configuration registers
	// ************************************************************
	// software settings that steer validation and the engines
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			cell_sel_q <= CELL_SEL_RESET;
			forbid_neighbour_q <= 1'b0;
			therm_check_on_q <= 1'b0;
			therm_thr_q <= THR_RESET;
			module_timer_q <= REG_RESET;
			host_pause_q <= 1'b0;
			irq_mask_q <= REG_RESET;
		end else if (i_ce && i_wr) begin
			unique case (i_addr)
				CELL_SEL_LO_OFS: cell_sel_q[7:0] <= i_wdata;
				CELL_SEL_HI_OFS: cell_sel_q[15:8] <= i_wdata;
				DEVICE_SETUP_REG_OFS: forbid_neighbour_q <= i_wdata[SETUP_FORBID_BIT];
				OVERTEMP_CFG_OFS: begin
					therm_check_on_q <= i_wdata[OTCFG_ON_BIT];
					therm_thr_q <= i_wdata[OTCFG_THR_LSB +: OTCFG_THR_W];
				end
				MODULE_TIMER_OFS: module_timer_q <= i_wdata;
				BALANCE_CTRL_OFS: host_pause_q <= i_wdata[CTRL_PAUSE_BIT];
				IRQ_MASK_OFS: irq_mask_q <= i_wdata;
				default: ;
			endcase
		end
	end

	// ************************************************************
	// launch validation
	// ************************************************************
	// rewritten on every launch write, kept otherwise
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			bad_setting_q <= 1'b0;
		end else if (i_ce && launch_wr) begin
			bad_setting_q <= bad_now;
		end
	end

	// ************************************************************
	// run state
	// ************************************************************
	// cell run stays set through pause; ends on completion, abort or a refused launch write
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			cell_run_q <= 1'b0;
		end else if (i_ce) begin
			if (launch_ok) begin
				cell_run_q <= 1'b1;
			end else if (launch_wr || abort_now || i_cell_done) begin
				cell_run_q <= 1'b0;
			end
		end
	end

	// module run only when the device times the module
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			module_run_q <= 1'b0;
		end else if (i_ce) begin
			if (launch_ok) begin
				module_run_q <= (module_timer_q != REG_RESET);
			end else if (launch_wr || i_module_done) begin
				module_run_q <= 1'b0;
			end
		end
	end

	// pause and overtemp follow the live condition so balancing resumes
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			overtemp_q <= 1'b0;
			paused_q <= 1'b0;
		end else if (i_ce) begin
			overtemp_q <= overtemp_now && !launch_wr;
			paused_q <= pause_now && !launch_wr;
		end
	end

	// ************************************************************
	// sticky completion and abort flags
	// ************************************************************
	// the launch write clears; a done event in the same cycle wins, a fault in that cycle is ignored
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			abort_q <= 1'b0;
			module_done_q <= 1'b0;
			cell_done_q <= 1'b0;
		end else if (i_ce) begin
			if (abort_now) begin
				abort_q <= 1'b1;
			end else if (launch_wr) begin
				abort_q <= 1'b0;
			end
			if (i_module_done && module_run_q) begin
				module_done_q <= 1'b1;
			end else if (launch_wr) begin
				module_done_q <= 1'b0;
			end
			if (i_cell_done && cell_run_q) begin
				cell_done_q <= 1'b1;
			end else if (launch_wr) begin
				cell_done_q <= 1'b0;
			end
		end
	end

	// ************************************************************
	// diagnostic ready flags
	// ************************************************************
	// finish wins over a start command in the same cycle
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			switch_ready_q <= 1'b0;
			aux_ready_q <= 1'b0;
		end else if (i_ce) begin
			if (i_switch_diag_done) begin
				switch_ready_q <= 1'b1;
			end else if (diag_start_wr) begin
				switch_ready_q <= 1'b0;
			end
			if (i_aux_diag_done) begin
				aux_ready_q <= 1'b1;
			end else if (diag_start_wr) begin
				aux_ready_q <= 1'b0;
			end
		end
	end

	// ************************************************************
	// pin levels
	// ************************************************************
	// one bit per pin, already two flops away from the pad
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			pin_level_q <= REG_RESET;
		end else if (i_ce) begin
			pin_level_q <= pin_sync;
		end
	end

	// ************************************************************
	// interrupts
	// ************************************************************
	always_comb begin
		irq_events = '0;
		irq_events[IRQ_REFUSED] = launch_wr && bad_now;
		irq_events[IRQ_ABORT] = abort_now;
		irq_events[IRQ_CELL_DONE] = i_cell_done && cell_run_q;
		irq_events[IRQ_MODULE_DONE] = i_module_done && module_run_q;
		irq_events[IRQ_OVERTEMP] = overtemp_now && !overtemp_q;
		irq_events[IRQ_SWITCH_DIAG] = i_switch_diag_done;
		irq_events[IRQ_AUX_DIAG] = i_aux_diag_done;
	end

	// write one to clear; a new event in the same cycle stays set
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			irq_status_q <= REG_RESET;
			o_irq <= 1'b0;
		end else if (i_ce) begin
			if (hit_wr(i_wr, i_addr, IRQ_STATUS_OFS)) begin
				irq_status_q <= (irq_status_q & ~i_wdata) | irq_events;
			end else begin
				irq_status_q <= irq_status_q | irq_events;
			end
			o_irq <= |(irq_status_q & irq_mask_q);
		end
	end

	// ************************************************************
	// engine controls
	// ************************************************************
	// go, abort and start are one-cycle pulses from flops
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			o_balance_go <= 1'b0;
			o_balance_pause <= 1'b0;
			o_balance_abort <= 1'b0;
			o_diag_start <= 1'b0;
			o_cell_select <= CELL_SEL_RESET;
			o_module_timer <= REG_RESET;
		end else if (i_ce) begin
			o_balance_go <= launch_ok;
			o_balance_pause <= pause_now && !launch_wr;
			o_balance_abort <= abort_now;
			o_diag_start <= diag_start_wr;
			o_cell_select <= cell_sel_q;
			o_module_timer <= module_timer_q;
		end
	end

	// ************************************************************
	// read port
	// ************************************************************
	always_comb begin
		bal_status = '0;
		bal_status[BS_BAD_SETTING] = bad_setting_q;
		bal_status[BS_OVERTEMP] = overtemp_q;
		bal_status[BS_PAUSED] = paused_q;
		bal_status[BS_MODULE_ACTIVE] = module_run_q;
		bal_status[BS_CELL_ACTIVE] = cell_run_q;
		bal_status[BS_FAULT_ABORT] = abort_q;
		bal_status[BS_MODULE_DONE] = module_done_q;
		bal_status[BS_CELL_DONE] = cell_done_q;
	end

	// data stand one cycle after the strobe only; reads change no state
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			o_rdata <= REG_RESET;
		end else if (i_ce) begin
			o_rdata <= REG_RESET;
			if (i_rd) begin
				unique case (i_addr)
					BALANCE_CTRL_OFS: o_rdata <= {6'h00, host_pause_q, 1'b0};
					CELL_SEL_LO_OFS: o_rdata <= cell_sel_q[7:0];
					CELL_SEL_HI_OFS: o_rdata <= cell_sel_q[15:8];
					DEVICE_SETUP_REG_OFS: o_rdata <= {7'h00, forbid_neighbour_q};
					OVERTEMP_CFG_OFS: o_rdata <= {3'h0, therm_check_on_q, therm_thr_q};
					MODULE_TIMER_OFS: o_rdata <= module_timer_q;
					DIAG_STATUS_OFS: o_rdata <= {6'h00, switch_ready_q, aux_ready_q};
					IRQ_STATUS_OFS: o_rdata <= irq_status_q;
					IRQ_MASK_OFS: o_rdata <= irq_mask_q;
					PIN_LEVEL_STATUS_OFS: o_rdata <= pin_level_q;
					BALANCING_STATUS_OFS: o_rdata <= bal_status;
					default: o_rdata <= REG_RESET;
				endcase
			end
		end
	end

endmodule

// ===== shared/cbs_pkg.sv
// constants, register map and field layout of the balancing status block
// Function
// - launch refused and invalid flag set when more than eight cells selected
// - with neighbour setting 0, more than two neighbouring cells is invalid
// - with neighbour setting 1, any two neighbouring cells is invalid
// - invalid flag re-evaluated on every launch write; 1 means invalid
// - thermistor reading above threshold sets overtemp pause flag when checking on
// - switch die heat warning also sets overtemp flag and pauses balancing
// - paused flag is 1 while paused by overtemp or host pause request
// - module active flag set while device-timed module balancing runs
// - cell active flag is 1 while any cell is being balanced
// - cell active flag stays 1 during pause
// - unmasked fault aborts cell balancing, sets abort flag; launch clears it
// - fault abort suppressed while paused, resumes after pause ends
// - module finished flag set on completion, cleared by launch
// - cell finished flag set when all cell balancing done, cleared by launch
// - eight pin level bits, 0 low and 1 high
// - switch diag ready set on finish, cleared by comparison start
// - cell versus aux diag ready set on finish, cleared by comparison start
package cbs_pkg;

	// ************************************************************
	// register map
	// ************************************************************
	localparam int ADDR_W = 12;
	localparam int DATA_W = 8;
	localparam int CELL_N = 16;
	localparam int THERM_N = 8;
	localparam logic [ADDR_W-1:0] BALANCE_CTRL_OFS = 12'h520;
	localparam logic [ADDR_W-1:0] CELL_SEL_LO_OFS = 12'h521;
	localparam logic [ADDR_W-1:0] CELL_SEL_HI_OFS = 12'h522;
	localparam logic [ADDR_W-1:0] DEVICE_SETUP_REG_OFS = 12'h523;
	localparam logic [ADDR_W-1:0] OVERTEMP_CFG_OFS = 12'h524;
	localparam logic [ADDR_W-1:0] MODULE_TIMER_OFS = 12'h525;
	localparam logic [ADDR_W-1:0] DIAG_CTRL_OFS = 12'h526;
	localparam logic [ADDR_W-1:0] DIAG_STATUS_OFS = 12'h527;
	localparam logic [ADDR_W-1:0] IRQ_STATUS_OFS = 12'h528;
	localparam logic [ADDR_W-1:0] IRQ_MASK_OFS = 12'h529;
	localparam logic [ADDR_W-1:0] PIN_LEVEL_STATUS_OFS = 12'h52A;
	localparam logic [ADDR_W-1:0] BALANCING_STATUS_OFS = 12'h52B;

	// ************************************************************
	// field positions
	// ************************************************************
	localparam int CTRL_LAUNCH_BIT = 0;
	localparam int CTRL_PAUSE_BIT = 1;
	localparam int SETUP_FORBID_BIT = 0;
	localparam int OTCFG_ON_BIT = 4;
	localparam int OTCFG_THR_LSB = 0;
	localparam int OTCFG_THR_W = 4;
	localparam int DIAG_START_BIT = 0;
	localparam int DIAG_AUX_BIT = 0;
	localparam int DIAG_SWITCH_BIT = 1;
	// balancing_status layout
	localparam int BS_BAD_SETTING = 7;
	localparam int BS_OVERTEMP = 6;
	localparam int BS_PAUSED = 5;
	localparam int BS_MODULE_ACTIVE = 4;
	localparam int BS_CELL_ACTIVE = 3;
	localparam int BS_FAULT_ABORT = 2;
	localparam int BS_MODULE_DONE = 1;
	localparam int BS_CELL_DONE = 0;
	// interrupt status / mask layout
	localparam int IRQ_REFUSED = 0;
	localparam int IRQ_ABORT = 1;
	localparam int IRQ_CELL_DONE = 2;
	localparam int IRQ_MODULE_DONE = 3;
	localparam int IRQ_OVERTEMP = 4;
	localparam int IRQ_SWITCH_DIAG = 5;
	localparam int IRQ_AUX_DIAG = 6;

	// ************************************************************
	// limits and reset values
	// ************************************************************
	localparam int MAX_SELECTED = 8;
	localparam int MAX_RUN_LOOSE = 2;
	localparam int MAX_RUN_STRICT = 1;
	localparam logic [DATA_W-1:0] REG_RESET = 8'h00;
	localparam logic [CELL_N-1:0] CELL_SEL_RESET = 16'h0000;
	localparam logic [3:0] THR_RESET = 4'hF;

endpackage

// ===== core/cbs_sync.sv
// two-flop synchroniser for asynchronous pin levels
`timescale 1ns/1ps
module cbs_sync #(
	parameter int WIDTH = 8
) (
	// clock, reset, enable
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic i_ce,
	// levels
	input wire logic [WIDTH-1:0] i_async,
	output logic [WIDTH-1:0] o_sync
);
	logic [WIDTH-1:0] meta_q;

	// first stage is read only by the second stage
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			meta_q <= '0;
			o_sync <= '0;
		end else if (i_ce) begin
			meta_q <= i_async;
			o_sync <= meta_q;
		end
	end
endmodule

// ===== core/cbs_cfg_check.sv
// combinational check of the cell selection against balancing limits
`timescale 1ns/1ps
module cbs_cfg_check
	import cbs_pkg::*;
(
	// selection and setting
	input wire logic [CELL_N-1:0] i_cells,
	input wire logic i_forbid_neighbour,
	// verdict
	output logic o_bad
);
	logic [4:0] count;
	logic [4:0] run;
	logic [4:0] max_run;

	// count selected cells and the longest run of neighbours
	always_comb begin
		count = '0;
		run = '0;
		max_run = '0;
		for (int i = 0; i < CELL_N; i++) begin
			count = count + 5'(i_cells[i]);
			run = i_cells[i] ? run + 5'h01 : 5'h00;
			if (run > max_run) begin
				max_run = run;
			end
		end
		o_bad = (count > 5'(MAX_SELECTED));
		if (i_forbid_neighbour) begin
			o_bad = o_bad | (max_run > 5'(MAX_RUN_STRICT));
		end else begin
			o_bad = o_bad | (max_run > 5'(MAX_RUN_LOOSE));
		end
	end
endmodule

// ===== bench/cbs_balance_status_properties.sv
// concurrent checks on the ports of the balancing status block
`timescale 1ns/1ps
module cbs_balance_status_properties
	import cbs_pkg::*;
(
	// clock, reset, enable
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic i_ce,
	// register port
	input wire logic [ADDR_W-1:0] i_addr,
	input wire logic [DATA_W-1:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	input wire logic [DATA_W-1:0] o_rdata,
	// engine side
	input wire logic i_fault,
	input wire logic [7:0] i_pin_level,
	input wire logic o_balance_go,
	input wire logic o_balance_pause,
	input wire logic o_balance_abort,
	input wire logic [CELL_N-1:0] o_cell_select,
	input wire logic o_diag_start
);
	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (i_rst);

	// ************************************************************
	// properties
	// ************************************************************
	// read data only in the cycle after a read strobe
	property p_rdata_idle;
		i_ce && !i_rd && !i_rst |=> o_rdata == 8'h00;
	endproperty
	a_rdata_idle: assert property (p_rdata_idle) else $error("read data not idle");
	// the selection copy lags one cycle, so only judge it when no select write just landed
	property p_go_many;
		i_ce && i_wr && i_addr == BALANCE_CTRL_OFS && i_wdata[CTRL_LAUNCH_BIT]
			&& $countones(o_cell_select) > MAX_SELECTED && $past(i_ce)
			&& !$past(i_wr && (i_addr == CELL_SEL_LO_OFS || i_addr == CELL_SEL_HI_OFS))
			|=> !o_balance_go;
	endproperty
	a_go_many: assert property (p_go_many) else $error("launch with too many cells");
	// a go pulse needs a launch write one cycle before
	property p_go_cause;
		o_balance_go && $past(i_ce) |->
			$past(i_wr && i_addr == BALANCE_CTRL_OFS && i_wdata[CTRL_LAUNCH_BIT]);
	endproperty
	a_go_cause: assert property (p_go_cause) else $error("go without launch");
	property p_diag_start;
		i_ce && !i_rst |=>
			o_diag_start == $past(i_wr && i_addr == DIAG_CTRL_OFS && i_wdata[DIAG_START_BIT]);
	endproperty
	a_diag_start: assert property (p_diag_start) else $error("diag start mismatch");
	property p_abort_cause;
		o_balance_abort && $past(i_ce) |-> $past(i_fault);
	endproperty
	a_abort_cause: assert property (p_abort_cause) else $error("abort without fault");
	property p_abort_pulse;
		o_balance_abort && i_ce |=> !o_balance_abort;
	endproperty
	a_abort_pulse: assert property (p_abort_pulse) else $error("abort not a pulse");
	// a settled pause blocks the fault abort
	property p_pause_guard;
		o_balance_pause ##1 o_balance_pause |-> !o_balance_abort;
	endproperty
	a_pause_guard: assert property (p_pause_guard) else $error("abort while paused");
	// two sync flops, the pin level register and the read register: four quiet cycles suffice
	property p_pin_level;
		(i_ce && !i_rst && $stable(i_pin_level)) [*4] ##0
			(i_rd && i_addr == PIN_LEVEL_STATUS_OFS) |=> o_rdata == $past(i_pin_level);
	endproperty
	a_pin_level: assert property (p_pin_level) else $error("pin level read wrong");

	// ************************************************************
	// coverage
	// ************************************************************
	c_launch: cover property (o_balance_go);
	c_abort: cover property (o_balance_abort);
	c_diag: cover property (o_diag_start);
	c_paused: cover property (o_balance_pause ##1 o_balance_pause);
endmodule

bind cbs_balance_status cbs_balance_status_properties cbs_balance_status_properties_i (
	.i_clk, .i_rst, .i_ce, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .i_fault,
	.i_pin_level, .o_balance_go, .o_balance_pause, .o_balance_abort, .o_cell_select,
	.o_diag_start
);

// ===== bench/cbs_balance_status_test.sv
// self-checking testbench for the balancing status block
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin n_compared++; if ((got) !== (exp)) begin mismatches++; \
	$display("unexpected %s: expected %h seen %h", nm, exp, got); end end
module cbs_balance_status_test
	import cbs_pkg::*;
;
	// ************************************************************
	// stimulus signals
	// ************************************************************
	logic i_clk = 1'b0;
	logic i_rst = 1'b1;
	logic i_ce = 1'b1;
	logic i_wr = 1'b0;
	logic i_rd = 1'b0;
	logic i_fault = 1'b0;
	logic i_heat_warn = 1'b0;
	logic [3:0] ev = 4'h0;
	logic [ADDR_W-1:0] i_addr = 12'h000;
	logic [DATA_W-1:0] i_wdata = 8'h00;
	logic [THERM_N*4-1:0] i_therm_reading = 32'h0000_0000;
	logic [7:0] i_pin_level = 8'h00;
	logic [DATA_W-1:0] o_rdata, o_module_timer;
	logic [CELL_N-1:0] o_cell_select;
	logic o_balance_go, o_balance_pause, o_balance_abort, o_diag_start, o_irq;
	int mismatches = 0;
	int n_compared = 0;

	always #2.5 i_clk = ~i_clk;

	cbs_balance_status cbs_balance_status_i (
		.i_clk, .i_rst, .i_ce, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata,
		.i_cell_done(ev[0]), .i_module_done(ev[1]), .i_fault, .i_heat_warn,
		.i_therm_reading, .i_switch_diag_done(ev[2]), .i_aux_diag_done(ev[3]),
		.i_pin_level, .o_balance_go, .o_balance_pause, .o_balance_abort, .o_cell_select,
		.o_module_timer, .o_diag_start, .o_irq
	);

	// ************************************************************
	// bus and event tasks
	// ************************************************************
	// a spare edge before each strobe keeps one assignment per time step
	task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		@(posedge i_clk);
		i_wr <= 1'b1;
		i_addr <= a;
		i_wdata <= d;
		@(posedge i_clk);
		i_wr <= 1'b0;
	endtask
	task automatic chk_rd(input string nm, input logic [ADDR_W-1:0] a,
		input logic [DATA_W-1:0] e);
		@(posedge i_clk);
		i_rd <= 1'b1;
		i_addr <= a;
		@(posedge i_clk);
		i_rd <= 1'b0;
		#1;
		`CHK(nm, e, o_rdata)
	endtask
	task automatic pulse(input logic [3:0] m);
		@(posedge i_clk);
		ev <= m;
		@(posedge i_clk);
		ev <= 4'h0;
	endtask
	task automatic launch(input logic [15:0] s);
		wr(CELL_SEL_LO_OFS, s[7:0]);
		wr(CELL_SEL_HI_OFS, s[15:8]);
		wr(BALANCE_CTRL_OFS, 8'h01);
	endtask
	// look just after the edge so registered outputs have landed
	task automatic settle;
		repeat (3) @(posedge i_clk);
		#1;
	endtask

	// ************************************************************
	// scenarios
	// ************************************************************
	task automatic t_reset;
		chk_rd("pin levels", PIN_LEVEL_STATUS_OFS, 8'h00);
		chk_rd("status", BALANCING_STATUS_OFS, 8'h00);
		chk_rd("overtemp setup", OVERTEMP_CFG_OFS, 8'h0F);
		wr(BALANCING_STATUS_OFS, 8'hFF);
		chk_rd("status after write", BALANCING_STATUS_OFS, 8'h00);
		chk_rd("unmapped", 12'h5FF, 8'h00);
		$display("reset test done");
	endtask
	// each launch re-judges the selection; verdicts run invalid, valid, valid, invalid, valid, invalid, valid
	task automatic t_config;
		logic [15:0] sel [7] = '{16'hD555, 16'h5555, 16'h5555, 16'h0007, 16'h0003, 16'h0003,
			16'h0005};
		logic fb [7] = '{1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1};
		logic [7:0] ex [7] = '{8'h80, 8'h08, 8'h08, 8'h80, 8'h08, 8'h80, 8'h08};
		for (int k = 0; k < 7; k++) begin
			wr(DEVICE_SETUP_REG_OFS, {7'h00, fb[k]});
			launch(sel[k]);
			chk_rd("launch verdict", BALANCING_STATUS_OFS, ex[k]);
		end
		$display("config test done");
	endtask
	task automatic t_run_done;
		wr(MODULE_TIMER_OFS, 8'h05);
		wr(IRQ_STATUS_OFS, 8'hFF);
		wr(IRQ_MASK_OFS, 8'h00);
		launch(16'h0101);
		chk_rd("run flags", BALANCING_STATUS_OFS, 8'h18);
		`CHK("module timer", 8'h05, o_module_timer)
		`CHK("cell select", 16'h0101, o_cell_select)
		pulse(4'h2);
		chk_rd("module finished", BALANCING_STATUS_OFS, 8'h0A);
		pulse(4'h1);
		chk_rd("cell finished", BALANCING_STATUS_OFS, 8'h03);
		chk_rd("irq status", IRQ_STATUS_OFS, 8'h0C);
		`CHK("masked irq", 1'b0, o_irq)
		wr(IRQ_MASK_OFS, 8'h04);
		settle;
		`CHK("unmasked irq", 1'b1, o_irq)
		wr(IRQ_STATUS_OFS, 8'h04);
		settle;
		`CHK("cleared irq", 1'b0, o_irq)
		launch(16'h0101);
		chk_rd("relaunch", BALANCING_STATUS_OFS, 8'h18);
		$display("run and done test done");
	endtask
	task automatic t_pause_fault;
		wr(MODULE_TIMER_OFS, 8'h00);
		launch(16'h0001);
		wr(BALANCE_CTRL_OFS, 8'h02);
		chk_rd("host pause", BALANCING_STATUS_OFS, 8'h28);
		@(posedge i_clk);
		i_fault <= 1'b1;
		settle;
		chk_rd("fault in pause", BALANCING_STATUS_OFS, 8'h28);
		wr(BALANCE_CTRL_OFS, 8'h00);
		settle;
		chk_rd("abort after pause", BALANCING_STATUS_OFS, 8'h04);
		@(posedge i_clk);
		i_fault <= 1'b0;
		launch(16'h0001);
		chk_rd("launch clears abort", BALANCING_STATUS_OFS, 8'h08);
		$display("pause and fault test done");
	endtask
	// the compare is strict, so a reading equal to the threshold is cool
	task automatic t_overtemp;
		wr(OVERTEMP_CFG_OFS, 8'h15);
		@(posedge i_clk);
		i_therm_reading <= 32'h0000_5000;
		settle;
		chk_rd("at threshold", BALANCING_STATUS_OFS, 8'h08);
		@(posedge i_clk);
		i_therm_reading <= 32'h0000_6000;
		settle;
		chk_rd("above threshold", BALANCING_STATUS_OFS, 8'h68);
		@(posedge i_clk);
		i_therm_reading <= 32'h0000_0000;
		i_heat_warn <= 1'b1;
		settle;
		chk_rd("heat warning", BALANCING_STATUS_OFS, 8'h68);
		@(posedge i_clk);
		i_heat_warn <= 1'b0;
		settle;
		chk_rd("cooled", BALANCING_STATUS_OFS, 8'h08);
		$display("overtemp test done");
	endtask
	task automatic t_pins_diag;
		@(posedge i_clk);
		i_pin_level <= 8'hA5;
		settle;
		chk_rd("pins", PIN_LEVEL_STATUS_OFS, 8'hA5);
		@(posedge i_clk);
		i_pin_level <= 8'h5A;
		settle;
		chk_rd("pins", PIN_LEVEL_STATUS_OFS, 8'h5A);
		pulse(4'hC);
		chk_rd("diag ready", DIAG_STATUS_OFS, 8'h03);
		chk_rd("diag ready reread", DIAG_STATUS_OFS, 8'h03);
		wr(DIAG_CTRL_OFS, 8'h01);
		chk_rd("diag cleared", DIAG_STATUS_OFS, 8'h00);
		// a low enable must swallow a finish pulse
		@(posedge i_clk);
		i_ce <= 1'b0;
		pulse(4'hC);
		@(posedge i_clk);
		i_ce <= 1'b1;
		chk_rd("frozen diag", DIAG_STATUS_OFS, 8'h00);
		$display("pins and diag test done");
	endtask

	// ************************************************************
	// sequence, watchdog and verdict
	// ************************************************************
	task automatic stop_test;
		$display("compared %0d, mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	initial begin
		repeat (6) @(posedge i_clk);
		i_rst <= 1'b0;
		t_reset;
		t_config;
		t_run_done;
		t_pause_fault;
		t_overtemp;
		t_pins_diag;
		stop_test;
	end
	// the scenarios need well under a thousand cycles
	initial begin
		repeat (5000) @(posedge i_clk);
		mismatches++;
		stop_test;
	end
endmodule
